// >>> core/timer_ctrl_pkg.sv
// Functional notes
// RULE1 - wave mode picks period or compare zero top
// RULE2 - update and overflow points follow wave mode
// RULE3 - normal mode drives no waveform
// RULE4 - pad gets waveform only with output enable
// RULE5 - value write sets outputs while timer stopped
// RULE6 - pad override needs channel output enable
// RULE7 - logic block path ignores output enable
// RULE8 - split bit selects two eight-bit timers
// RULE9 - clear register: one clears, zero keeps
// RULE10 - set register: one sets, zero keeps
// RULE11 - command field decodes update, restart, reset
// RULE12 - command field always reads zero
// RULE13 - lock skips transfers, forced update still happens
// RULE14 - direction zero counts up, one down
// RULE15 - direction driven by hardware and software
// RULE16 - compare buffer write sets flag, update clears
// RULE17 - period buffer write sets flag, update clears
// RULE18 - auto lock holds until enabled buffers valid
// RULE19 - set and clear registers read same bits
// RULE20 - software avoids reserved wave mode codes
package timer_ctrl_pkg;

  // ****************************************
  // register indices, byte address is four times
  // ****************************************
  localparam logic [5:0] IDX_TIMER_CONTROL = 6'h00;
  localparam logic [5:0] IDX_WAVE_CONTROL = 6'h01;
  localparam logic [5:0] IDX_COMPARE_OUTPUT_VALUE = 6'h02;
  localparam logic [5:0] IDX_SPLIT_MODE_CONTROL = 6'h03;
  localparam logic [5:0] IDX_COMMAND_DIRECTION_CLEAR = 6'h04;
  localparam logic [5:0] IDX_COMMAND_DIRECTION_SET = 6'h05;
  localparam logic [5:0] IDX_BUFFER_VALID_CLEAR = 6'h06;
  localparam logic [5:0] IDX_BUFFER_VALID_SET = 6'h07;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int ENABLE_BIT = 0;
  localparam int WAVE_MODE_LSB = 0;
  localparam int AUTO_LOCK_BIT = 3;
  localparam int OUT_ENABLE_LSB = 4;
  localparam int SPLIT_BIT = 0;
  localparam int DIR_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int CMD_LSB = 2;
  localparam int PERIOD_BV_BIT = 0;
  localparam int CMP_BV_LSB = 1;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ****************************************
  // wave modes, commands, bus answers
  // ****************************************
  localparam logic [2:0] WAVE_NORMAL = 3'h0;
  localparam logic [2:0] WAVE_FREQUENCY = 3'h1;
  localparam logic [2:0] WAVE_SINGLE_SLOPE = 3'h3;
  localparam logic [2:0] WAVE_DS_TOP = 3'h5;
  localparam logic [2:0] WAVE_DS_BOTH = 3'h6;
  localparam logic [2:0] WAVE_DS_BOTTOM = 3'h7;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_UPDATE = 2'h1;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_HARD_RESET = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_s;

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic timer_enable;
    logic [2:0] wave_mode;
    logic auto_lock_update;
    logic [2:0] compare_output_enable;
    logic [2:0] compare_output_value;
    logic split_operation;
    logic lock_update;
    logic dir;
    logic [3:0] buffer_valid;
    logic [2:0] wave_value;
    logic update_point;
    logic overflow_point;
    logic buffer_transfer;
    logic restart_pulse;
    logic hard_reset_pulse;
  } ctrl_state_s;

  localparam ctrl_state_s STATE_RESET = '0;

endpackage : timer_ctrl_pkg

// >>> core/timer_wave_control.sv
`timescale 1ns/1ps
module timer_wave_control
  import timer_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire axi_req_s bus_req,
  output axi_rsp_s bus_rsp,
  input wire logic counter_at_top,
  input wire logic counter_at_bottom,
  input wire logic [2:0] wave_gen_in,
  input wire logic period_buffer_write,
  input wire logic [2:0] compare_buffer_write,
  output logic timer_enable,
  output logic top_from_compare_zero,
  output logic update_point,
  output logic overflow_point,
  output logic buffer_transfer,
  output logic count_down,
  output logic split_operation,
  output logic restart_pulse,
  output logic hard_reset_pulse,
  output logic [2:0] pad_wave,
  output logic [2:0] pad_override,
  output logic [2:0] logic_wave
);

  ctrl_state_s st;
  ctrl_state_s next_st;

  // ****************************************
  // read view
  // ****************************************
  function automatic logic [8:0] read_reg(
    input ctrl_state_s s,
    input logic [7:0] addr
  );
    logic [7:0] v;
    logic ok;
    v = REG_RESET;
    ok = (addr[1:0] == 2'h0);
    case (addr[7:2])
      IDX_TIMER_CONTROL: v[ENABLE_BIT] = s.timer_enable;
      IDX_WAVE_CONTROL: begin
        v[WAVE_MODE_LSB +: 3] = s.wave_mode;
        v[AUTO_LOCK_BIT] = s.auto_lock_update;
        v[OUT_ENABLE_LSB +: 3] = s.compare_output_enable;
      end
      IDX_COMPARE_OUTPUT_VALUE: v[2:0] = s.compare_output_value;
      IDX_SPLIT_MODE_CONTROL: v[SPLIT_BIT] = s.split_operation;
      // command bits stay zero in the view
      IDX_COMMAND_DIRECTION_CLEAR, IDX_COMMAND_DIRECTION_SET: begin
        v[DIR_BIT] = s.dir; // RULE12 RULE19
        v[LOCK_BIT] = s.lock_update;
      end
      IDX_BUFFER_VALID_CLEAR, IDX_BUFFER_VALID_SET: begin
        v[3:0] = s.buffer_valid; // RULE19
      end
      default: ok = 1'b0;
    endcase
    return {ok, v};
  endfunction : read_reg

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic [7:0] waddr;
    logic [7:0] wdat;
    logic wlane;
    logic do_write;
    logic hit;
    logic wr;
    logic [5:0] widx;
    logic [1:0] cmd;
    logic force_update;
    logic upd;
    logic ovf;
    logic up;
    logic transfer;
    logic all_valid;
    logic [8:0] rd;
    aw_take = 1'b0;
    w_take = 1'b0;
    ar_take = 1'b0;
    waddr = 8'h00;
    wdat = 8'h00;
    wlane = 1'b0;
    do_write = 1'b0;
    hit = 1'b0;
    wr = 1'b0;
    widx = 6'h00;
    cmd = CMD_NONE;
    force_update = 1'b0;
    upd = 1'b0;
    ovf = 1'b0;
    up = 1'b0;
    transfer = 1'b0;
    all_valid = 1'b0;
    rd = 9'h000;
    next_st = st;

    // ****************************************
    // write channel: address and data in either order
    // ****************************************
    aw_take = bus_req.awvalid & bus_rsp.awready;
    w_take = bus_req.wvalid & bus_rsp.wready;
    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = bus_req.awaddr;
    end
    if (w_take) begin
      next_st.w_held = 1'b1;
      next_st.w_data = bus_req.wdata[7:0];
      next_st.w_lane = bus_req.wstrb[0];
    end
    waddr = aw_take ? bus_req.awaddr : st.aw_addr;
    wdat = w_take ? bus_req.wdata[7:0] : st.w_data;
    wlane = w_take ? bus_req.wstrb[0] : st.w_lane;
    do_write = (st.aw_held | aw_take) & (st.w_held | w_take) & ~st.bvalid;
    widx = waddr[7:2];
    hit = (waddr[1:0] == 2'h0) & (widx <= IDX_BUFFER_VALID_SET);
    // registers sit in byte lane zero; other lanes are ignored
    wr = do_write & hit & wlane;
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st.bvalid & bus_req.bready) begin
      next_st.bvalid = 1'b0;
    end

    // ****************************************
    // read channel
    // ****************************************
    ar_take = bus_req.arvalid & bus_rsp.arready;
    if (ar_take) begin
      rd = read_reg(st, bus_req.araddr);
      next_st.rvalid = 1'b1;
      next_st.rdata = rd[7:0];
      next_st.rresp = rd[8] ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid & bus_req.rready) begin
      next_st.rvalid = 1'b0;
    end

    // ****************************************
    // software writes
    // ****************************************
    if (wr) begin
      case (widx)
        IDX_TIMER_CONTROL: next_st.timer_enable = wdat[ENABLE_BIT];
        IDX_WAVE_CONTROL: begin
          next_st.wave_mode = wdat[WAVE_MODE_LSB +: 3];
          next_st.auto_lock_update = wdat[AUTO_LOCK_BIT];
          next_st.compare_output_enable = wdat[OUT_ENABLE_LSB +: 3];
          // switching auto lock on locks at once
          if (wdat[AUTO_LOCK_BIT] & ~st.auto_lock_update) begin
            next_st.lock_update = 1'b1; // RULE18
          end
        end
        IDX_COMPARE_OUTPUT_VALUE: begin
          next_st.compare_output_value = wdat[2:0];
          if (~st.timer_enable) begin
            next_st.wave_value = wdat[2:0]; // RULE5
          end
        end
        IDX_SPLIT_MODE_CONTROL: next_st.split_operation = wdat[SPLIT_BIT]; // RULE8
        IDX_COMMAND_DIRECTION_CLEAR: begin
          if (wdat[DIR_BIT]) next_st.dir = 1'b0; // RULE9 RULE15
          if (wdat[LOCK_BIT]) next_st.lock_update = 1'b0; // RULE9
          cmd = wdat[CMD_LSB +: 2];
        end
        IDX_COMMAND_DIRECTION_SET: begin
          if (wdat[DIR_BIT]) next_st.dir = 1'b1; // RULE10 RULE15
          if (wdat[LOCK_BIT]) next_st.lock_update = 1'b1; // RULE10
          cmd = wdat[CMD_LSB +: 2];
        end
        IDX_BUFFER_VALID_CLEAR: begin
          next_st.buffer_valid = st.buffer_valid & ~wdat[3:0]; // RULE9
        end
        IDX_BUFFER_VALID_SET: begin
          next_st.buffer_valid = st.buffer_valid | wdat[3:0]; // RULE10
        end
        default: next_st.bresp = RESP_SLVERR;
      endcase
    end

    // ****************************************
    // commands, never stored so they read back zero
    // ****************************************
    next_st.restart_pulse = 1'b0;
    next_st.hard_reset_pulse = 1'b0;
    case (cmd)
      CMD_UPDATE: force_update = 1'b1; // RULE11
      CMD_RESTART: next_st.restart_pulse = 1'b1; // RULE11
      CMD_HARD_RESET: next_st.hard_reset_pulse = ~st.timer_enable; // RULE11
      default: force_update = 1'b0;
    endcase

    // ****************************************
    // update and overflow points
    // ****************************************
    up = ~st.dir; // RULE14
    case (st.wave_mode)
      WAVE_NORMAL, WAVE_FREQUENCY: begin
        upd = counter_at_top & up; // RULE2
        ovf = counter_at_top & up;
      end
      WAVE_SINGLE_SLOPE: begin
        upd = counter_at_bottom; // RULE2
        ovf = counter_at_bottom;
      end
      WAVE_DS_TOP: begin
        upd = counter_at_bottom; // RULE2
        ovf = counter_at_top;
      end
      WAVE_DS_BOTH: begin
        upd = counter_at_bottom; // RULE2
        ovf = counter_at_top | counter_at_bottom;
      end
      WAVE_DS_BOTTOM: begin
        upd = counter_at_bottom; // RULE2
        ovf = counter_at_bottom;
      end
      // reserved codes raise no points
      default: upd = 1'b0;
    endcase
    upd = upd & st.timer_enable;
    ovf = ovf & st.timer_enable;
    transfer = (upd & ~st.lock_update) | force_update; // RULE13
    next_st.update_point = upd;
    next_st.overflow_point = ovf;
    next_st.buffer_transfer = transfer;

    // ****************************************
    // dual slope turns the count at each end
    // ****************************************
    if (st.timer_enable & st.wave_mode[2] & st.wave_mode != 3'h4) begin
      if (counter_at_top) next_st.dir = 1'b1; // RULE15
      if (counter_at_bottom) next_st.dir = 1'b0; // RULE15
    end

    // ****************************************
    // buffer valid flags, a buffer write beats a transfer or register clear; a hard reset clears it
    // ****************************************
    if (transfer) begin
      next_st.buffer_valid = 4'h0; // RULE16 RULE17
    end
    if (period_buffer_write) begin
      next_st.buffer_valid[PERIOD_BV_BIT] = 1'b1; // RULE17
    end
    next_st.buffer_valid[CMP_BV_LSB +: 3] =
      next_st.buffer_valid[CMP_BV_LSB +: 3] | compare_buffer_write; // RULE16

    // ****************************************
    // auto lock; no enabled channel counts as all valid
    // ****************************************
    all_valid = &(st.buffer_valid[CMP_BV_LSB +: 3] | ~st.compare_output_enable);
    if (st.auto_lock_update) begin
      if (transfer) begin
        next_st.lock_update = 1'b1; // RULE18
      end else if (all_valid) begin
        next_st.lock_update = 1'b0; // RULE18
      end
    end

    // ****************************************
    // waveform value follows the generator while running in any mode but normal
    // ****************************************
    if (st.timer_enable & st.wave_mode != WAVE_NORMAL) begin
      next_st.wave_value = wave_gen_in; // RULE3
    end

    // ****************************************
    // hard reset returns the counting state to idle
    // ****************************************
    if (next_st.hard_reset_pulse) begin
      next_st.dir = 1'b0;
      next_st.lock_update = 1'b0;
      next_st.buffer_valid = 4'h0;
      next_st.wave_value = 3'h0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bus_rsp.awready = ~st.aw_held & ~st.bvalid;
  assign bus_rsp.wready = ~st.w_held & ~st.bvalid;
  assign bus_rsp.bvalid = st.bvalid;
  assign bus_rsp.bresp = st.bresp;
  assign bus_rsp.arready = ~st.rvalid;
  assign bus_rsp.rvalid = st.rvalid;
  assign bus_rsp.rdata = {24'h000000, st.rdata};
  assign bus_rsp.rresp = st.rresp;

  // ****************************************
  // timer side
  // ****************************************
  assign timer_enable = st.timer_enable;
  assign top_from_compare_zero = (st.wave_mode == WAVE_FREQUENCY); // RULE1
  assign update_point = st.update_point;
  assign overflow_point = st.overflow_point;
  assign buffer_transfer = st.buffer_transfer;
  assign count_down = st.dir; // RULE14
  assign split_operation = st.split_operation;
  assign restart_pulse = st.restart_pulse;
  assign hard_reset_pulse = st.hard_reset_pulse;

  // ****************************************
  // waveform routing, one copy per channel
  // ****************************************
  for (genvar ch = 0; ch < 3; ch++) begin : g_channel
    logic pad_live;
    // a stopped timer lets the value override show; running normal mode shows nothing
    assign pad_live = ~st.timer_enable | (st.wave_mode != WAVE_NORMAL); // RULE3
    // the pad needs the channel enable
    assign pad_override[ch] = st.compare_output_enable[ch] & pad_live; // RULE4 RULE6
    assign pad_wave[ch] = st.wave_value[ch];
    // the logic block path bypasses the enable on purpose
    assign logic_wave[ch] = st.wave_value[ch]; // RULE7
  end : g_channel

endmodule : timer_wave_control

// >>> bench/timer_wave_control_sva.sv
`timescale 1ns/1ps
module timer_wave_control_sva
  import timer_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire axi_req_s bus_req,
  input wire axi_rsp_s bus_rsp,
  input wire logic counter_at_top,
  input wire logic counter_at_bottom,
  input wire logic timer_enable,
  input wire logic update_point,
  input wire logic overflow_point,
  input wire logic restart_pulse,
  input wire logic hard_reset_pulse,
  input wire logic split_operation
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ************
  // bus timing
  // ************
  a_write_answer: assert property (bus_req.awvalid && bus_rsp.awready && bus_req.wvalid &&
    bus_rsp.wready |=> bus_rsp.bvalid) else $error("write not answered");
  a_bresp_stands: assert property (bus_rsp.bvalid && !bus_req.bready |=>
    bus_rsp.bvalid && $stable(bus_rsp.bresp)) else $error("write answer dropped");
  a_read_answer: assert property (bus_req.arvalid && bus_rsp.arready |=> bus_rsp.rvalid)
    else $error("read not answered");
  a_rdata_stands: assert property (bus_rsp.rvalid && !bus_req.rready |=>
    bus_rsp.rvalid && $stable(bus_rsp.rdata)) else $error("read answer dropped");
  a_upper_zero: assert property (bus_rsp.rvalid |-> bus_rsp.rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // ************
  // timer side
  // ************
  a_hard_gated: assert property (hard_reset_pulse |-> !$past(timer_enable))
    else $error("hard reset while running");
  a_restart_once: assert property (restart_pulse |=> !restart_pulse)
    else $error("restart pulse too long");
  a_update_cause: assert property (update_point |->
    $past(timer_enable) && $past(counter_at_top || counter_at_bottom))
    else $error("update point without cause");
  a_overflow_cause: assert property (overflow_point |->
    $past(timer_enable) && $past(counter_at_top || counter_at_bottom))
    else $error("overflow point without cause");
  // reset edge itself changes the bit, so it is excluded
  a_split_write: assert property ($changed(split_operation) && $past(rst_n) |->
    $rose(bus_rsp.bvalid)) else $error("split bit moved without write");
  c_update: cover property (update_point);
  c_overflow: cover property (overflow_point);
  c_restart: cover property (restart_pulse);
  c_hard: cover property (hard_reset_pulse);
endmodule : timer_wave_control_sva

bind timer_wave_control timer_wave_control_sva chk_u (.mclk, .rst_n, .bus_req, .bus_rsp,
  .counter_at_top, .counter_at_bottom, .timer_enable, .update_point, .overflow_point,
  .restart_pulse, .hard_reset_pulse, .split_operation);

// >>> bench/timer_wave_control_tb.sv
`timescale 1ns/1ps
module timer_wave_control_tb
  import timer_ctrl_pkg::*;
;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
  logic mclk = 0;
  logic rst_n = 0;
  logic top = 0;
  logic bot = 0;
  logic pbw = 0;
  logic [2:0] wgi = 0;
  logic [2:0] cbw = 0;
  axi_req_s req = '0;
  axi_rsp_s rsp;
  logic en_o, tz, up, ov, bt, cd, sp, rs, hr;
  logic [2:0] pw, po, lw;
  logic [4:0] seen = '0;
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  logic [7:0] v;
  int err_count = 0;
  int checks = 0;
  int seed = 95;
  // points per mode: update top, overflow top, update bottom, overflow bottom
  logic [3:0] pts [8] = '{4'hc, 4'hc, 4'h0, 4'h3, 4'h0, 4'h6, 4'h7, 4'h3};

  always #50 mclk = ~mclk;

  timer_wave_control dut_u (.mclk(mclk), .rst_n(rst_n), .bus_req(req), .bus_rsp(rsp),
    .counter_at_top(top), .counter_at_bottom(bot), .wave_gen_in(wgi),
    .period_buffer_write(pbw), .compare_buffer_write(cbw), .timer_enable(en_o),
    .top_from_compare_zero(tz), .update_point(up), .overflow_point(ov),
    .buffer_transfer(bt), .count_down(cd), .split_operation(sp), .restart_pulse(rs),
    .hard_reset_pulse(hr), .pad_wave(pw), .pad_override(po), .logic_wave(lw));

  // ************
  // result watcher
  // ************
  always @(posedge mclk) begin
    seen <= seen | {up, ov, bt, rs, hr};
    if (rsp.rvalid && req.rready) begin
      `CHK("rdata", rq[0][31:0], rsp.rdata)
      `CHK("rresp", rq[0][33:32], rsp.rresp)
      rq.delete(0);
    end
    if (rsp.bvalid && req.bready) begin
      `CHK("bresp", bq[0], rsp.bresp)
      bq.delete(0);
    end
  end

  task test_done;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task clr;
    @(negedge mclk);
    seen = '0;
    @(posedge mclk);
  endtask : clr

  // one transfer; requests held until ready was seen high before the edge
  task bus(input logic wn, input logic [5:0] i, input logic [7:0] d,
      input logic [1:0] e = RESP_OKAY);
    logic a, w, g;
    int n;
    n = 0;
    if (wn) bq.push_back(e);
    else rq.push_back({e, 24'h0, d});
    req.awvalid <= wn;
    req.wvalid <= wn;
    req.bready <= wn;
    req.arvalid <= !wn;
    req.rready <= !wn;
    req.awaddr <= {i, 2'h0};
    req.araddr <= {i, 2'h0};
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hf;
    do begin
      @(negedge mclk);
      a = (req.awvalid && rsp.awready) || (req.arvalid && rsp.arready);
      w = req.wvalid && rsp.wready;
      g = wn ? rsp.bvalid : rsp.rvalid;
      @(posedge mclk);
      if (a) begin
        req.awvalid <= 0;
        req.arvalid <= 0;
      end
      if (w) req.wvalid <= 0;
      n++;
    end while (!g && n < 50);
    req.bready <= 0;
    req.rready <= 0;
    // an idle edge, so the next call never rewrites a signal in this step
    @(posedge mclk);
    if (!g) begin
      err_count++;
      test_done();
    end
  endtask : bus

  task pulse(input logic t, input logic b, input logic [2:0] c, input logic p);
    clr();
    top <= t;
    bot <= b;
    cbw <= c;
    pbw <= p;
    @(posedge mclk);
    top <= 0;
    bot <= 0;
    cbw <= 0;
    pbw <= 0;
    tick(3);
  endtask : pulse

  // ************
  // main sequence
  // ************
  initial begin
    tick(10);
    rst_n <= 1;
    for (int i = 0; i < 8; i++) bus(0, i[5:0], REG_RESET);
    bus(0, 6'h8, 8'h00, RESP_SLVERR);
    bus(1, 6'h9, 8'hff, RESP_SLVERR);
    for (int k = 0; k < 4; k++) begin
      bus(1, 6'h1, {1'b0, k[1], 1'b0, k[1], 4'h0});
      v = 8'($random(seed));
      bus(1, 6'h2, v);
      tick(2);
      `CHK("logic_wave", v[2:0], lw)
      `CHK("pad_wave", v[2:0], pw)
      `CHK("pad_override", {k[1], 1'b0, k[1]}, po)
    end
    for (int m = 0; m < 8; m++) begin
      if (m == 2 || m == 4) continue;
      bus(1, 6'h1, {4'h5, 1'b0, m[2:0]});
      `CHK("top_select", m == 1, tz)
    end
    bus(1, 6'h0, 8'h01);
    `CHK("timer_enable", 1'b1, en_o)
    for (int m = 0; m < 8; m++) begin
      if (m == 2 || m == 4) continue;
      bus(1, 6'h1, {4'h5, 1'b0, m[2:0]});
      wgi <= 3'($random(seed));
      tick(3);
      `CHK("pad_override", (m == 0) ? 3'h0 : 3'h5, po)
      if (m != 0) `CHK("pad_wave", wgi, pw)
      pulse(1, 0, 3'h0, 0);
      `CHK("top_points", pts[m][3:2], seen[4:3])
      `CHK("top_transfer", pts[m][3], seen[2])
      `CHK("dir_top", m > 4, cd)
      pulse(0, 1, 3'h0, 0);
      `CHK("bottom_points", pts[m][1:0], seen[4:3])
      `CHK("dir_bottom", 1'b0, cd)
    end
    bus(1, 6'h1, 8'h50);
    pulse(0, 0, 3'h7, 1);
    bus(0, 6'h6, 8'h0f);
    bus(0, 6'h7, 8'h0f);
    bus(1, 6'h5, 8'h02);
    pulse(1, 0, 3'h0, 0);
    `CHK("locked_update", 2'h2, seen[3:2])
    bus(0, 6'h6, 8'h0f);
    clr();
    bus(1, 6'h5, {4'h0, CMD_UPDATE, 2'h0});
    tick(2);
    `CHK("forced_update", 1'b1, seen[2])
    bus(0, 6'h6, 8'h00);
    bus(0, 6'h5, 8'h02);
    bus(1, 6'h4, 8'h00);
    bus(0, 6'h4, 8'h02);
    bus(1, 6'h5, 8'h01);
    bus(0, 6'h5, 8'h03);
    `CHK("count_down", 1'b1, cd)
    bus(1, 6'h4, 8'h03);
    bus(0, 6'h4, 8'h00);
    `CHK("count_up", 1'b0, cd)
    bus(1, 6'h7, 8'h05);
    bus(1, 6'h6, 8'h01);
    bus(0, 6'h7, 8'h04);
    clr();
    bus(1, 6'h5, {4'h0, CMD_NONE, 2'h0});
    bus(1, 6'h5, {4'h0, CMD_HARD_RESET, 2'h0});
    bus(1, 6'h4, {4'h0, CMD_RESTART, 2'h0});
    tick(2);
    `CHK("cmd_running", 3'h2, seen[2:0])
    bus(1, 6'h0, 8'h00);
    `CHK("timer_disable", 1'b0, en_o)
    clr();
    bus(1, 6'h5, {4'h0, CMD_HARD_RESET, 2'h0});
    tick(2);
    `CHK("cmd_stopped", 2'h1, seen[1:0])
    bus(1, 6'h3, 8'h01);
    bus(0, 6'h3, 8'h01);
    `CHK("split", 1'b1, sp)
    bus(1, 6'h1, 8'h18);
    bus(0, 6'h4, 8'h02);
    pulse(0, 0, 3'h1, 0);
    bus(0, 6'h4, 8'h00);
    test_done();
  end
endmodule : timer_wave_control_tb
